/* File: src/alfc_device.sv */
`timescale 1ns/1ps
`default_nettype none
`include "alfc_defines.svh"

// What this block does
// - input-two absence flag latches, held until cleared
// - input-one absence flag latches, held until cleared
// - reference absence flag latches, held until cleared
// - input-two offset flag latches, held until cleared
// - input-one offset flag latches, held until cleared
// - unlock flag latches while PLL unlocked
// - writing zero clears a flag bit
// - interrupt when unmasked flag set and enabled
// - per-flag mask blocks interrupt, flag stays readable
// - part identifier split across two registers
// - revision number in low nibble
// - soft reset bit resets all logic
// - host waits 10 ms after soft reset
// - calibrate bit starts calibration, self-clears
// - calibration done when unlock alarm low
// - host needs stable input clock first
// - config changes apply only at calibration
// - host must run calibration before use
// - live input-two absence alarm drives flag
module alfc_device #(
  parameter logic [11:0] PART_ID = 12'h5a3, // arbitrary value
  parameter logic [3:0] REV_ID = 4'hb // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port and interrupt pin
  alfc_if.dev port,
  // live alarms from the monitors
  input wire logic in2_absent_live,
  input wire logic in1_absent_live,
  input wire logic ref_absent_live,
  input wire logic in2_offset_live,
  input wire logic in1_offset_live,
  input wire logic unlock_live,
  // interrupt masks and pin enable
  input wire logic in2_absent_mask,
  input wire logic in1_absent_mask,
  input wire logic ref_absent_mask,
  input wire logic in2_offset_mask,
  input wire logic in1_offset_mask,
  input wire logic unlock_mask,
  input wire logic int_pin_enable,
  // pending configuration
  input wire logic [3:0] loop_bandwidth_select,
  input wire logic [2:0] input_rate_select,
  // calibration and reset toward the PLL
  output logic cal_start_r,
  output logic calibrating_r,
  output logic [3:0] bandwidth_active_r,
  output logic [2:0] rate_active_r,
  output logic logic_reset_r
);
  import alfc_pkg::*;

  // ----------------------------------------------------------------
  // reset
  // ----------------------------------------------------------------
  logic rst_all;
  logic ack_r;
  logic irq_r;
  alfc_byte_t rdata_r;
  alfc_byte_t absent_r;
  alfc_byte_t offset_r;

  // soft reset acts just like the pin for one cycle
  assign rst_all = sys_rst | logic_reset_r;

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  logic take;
  logic wr;
  logic wr_absent;
  logic wr_offset;
  logic wr_ctrl;
  logic soft_wr;
  logic cal_wr;

  // a held request is taken once, the cycle before ack
  assign take = port.req & ~ack_r;
  assign wr = take & port.we;
  assign wr_absent = wr & (port.addr == `ALFC_OFF_ABSENT);
  assign wr_offset = wr & (port.addr == `ALFC_OFF_OFFSET);
  assign wr_ctrl = wr & (port.addr == `ALFC_OFF_CTRL);
  assign soft_wr = wr_ctrl & port.wdata[`ALFC_BIT_SOFT_RESET];
  // reset wins over a calibrate in the same write
  assign cal_wr = wr_ctrl & port.wdata[`ALFC_BIT_CALIBRATE] & ~soft_wr;

  // ----------------------------------------------------------------
  // sticky flags
  // ----------------------------------------------------------------
  alfc_byte_t absent_live;
  alfc_byte_t offset_live;
  alfc_byte_t absent_clr;
  alfc_byte_t offset_clr;
  alfc_byte_t absent_nxt;
  alfc_byte_t offset_nxt;

  always_comb begin
    absent_live = `ALFC_BYTE_ZERO;
    offset_live = `ALFC_BYTE_ZERO;
    absent_live[`ALFC_BIT_IN2_ABSENT] = in2_absent_live;
    absent_live[`ALFC_BIT_IN1_ABSENT] = in1_absent_live;
    absent_live[`ALFC_BIT_REF_ABSENT] = ref_absent_live;
    offset_live[`ALFC_BIT_IN2_OFFSET] = in2_offset_live;
    offset_live[`ALFC_BIT_IN1_OFFSET] = in1_offset_live;
    offset_live[`ALFC_BIT_UNLOCK] = unlock_live;
  end

  // a zero written clears; ones leave the bit alone
  assign absent_clr = wr_absent ? ~port.wdata : `ALFC_BYTE_ZERO;
  assign offset_clr = wr_offset ? ~port.wdata : `ALFC_BYTE_ZERO;

  // live alarm ORed last so an event never loses to a clear
  assign absent_nxt = (absent_live | (absent_r & ~absent_clr))
                      & `ALFC_ABSENT_BITS;
  assign offset_nxt = (offset_live | (offset_r & ~offset_clr))
                      & `ALFC_OFFSET_BITS;

  always_ff @(posedge clk) begin
    if (rst_all) begin
      absent_r <= `ALFC_BYTE_ZERO;
      offset_r <= `ALFC_BYTE_ZERO;
    end else begin
      absent_r <= absent_nxt;
      offset_r <= offset_nxt;
    end
  end

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  alfc_byte_t absent_msk;
  alfc_byte_t offset_msk;

  always_comb begin
    absent_msk = `ALFC_BYTE_ZERO;
    offset_msk = `ALFC_BYTE_ZERO;
    absent_msk[`ALFC_BIT_IN2_ABSENT] = in2_absent_mask;
    absent_msk[`ALFC_BIT_IN1_ABSENT] = in1_absent_mask;
    absent_msk[`ALFC_BIT_REF_ABSENT] = ref_absent_mask;
    offset_msk[`ALFC_BIT_IN2_OFFSET] = in2_offset_mask;
    offset_msk[`ALFC_BIT_IN1_OFFSET] = in1_offset_mask;
    offset_msk[`ALFC_BIT_UNLOCK] = unlock_mask;
  end

  // pin follows the stored flags, one cycle behind them
  always_ff @(posedge clk) begin
    if (rst_all) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= int_pin_enable & (|(absent_r & ~absent_msk) |
                                 |(offset_r & ~offset_msk));
    end
  end

  assign port.irq = irq_r;

  // ----------------------------------------------------------------
  // read path and acknowledge
  // ----------------------------------------------------------------
  alfc_byte_t rd_mux;

  always_comb begin
    rd_mux = `ALFC_BYTE_ZERO;
    unique case (port.addr)
      `ALFC_OFF_ABSENT: rd_mux = absent_r;
      `ALFC_OFF_OFFSET: rd_mux = offset_r;
      `ALFC_OFF_ID_HI: rd_mux = PART_ID[`ALFC_ID_HI_MSB:`ALFC_ID_HI_LSB];
      `ALFC_OFF_ID_LO: rd_mux = {PART_ID[`ALFC_ID_LO_MSB:`ALFC_ID_LO_LSB],
                                 REV_ID};
      // both control bits clear themselves, so they read zero
      default: rd_mux = `ALFC_BYTE_ZERO;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      ack_r <= 1'b0;
      rdata_r <= `ALFC_BYTE_ZERO;
    end else begin
      ack_r <= take;
      if (take) begin
        rdata_r <= port.we ? `ALFC_BYTE_ZERO : rd_mux;
      end
    end
  end

  assign port.ack = ack_r;
  assign port.rdata = rdata_r;

  // ----------------------------------------------------------------
  // soft reset
  // ----------------------------------------------------------------
  // one cycle is enough here: every other flop shares the same reset term
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      logic_reset_r <= 1'b0;
    end else if (logic_reset_r) begin
      logic_reset_r <= 1'b0;
    end else begin
      logic_reset_r <= soft_wr;
    end
  end

  // ----------------------------------------------------------------
  // calibration
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst_all) begin
      cal_start_r <= 1'b0;
    end else begin
      cal_start_r <= cal_wr;
    end
  end

  // busy ends once the unlock alarm reads low after the start
  always_ff @(posedge clk) begin
    if (rst_all) begin
      calibrating_r <= 1'b0;
    end else if (cal_wr) begin
      calibrating_r <= 1'b1;
    end else if (~unlock_live) begin
      calibrating_r <= 1'b0;
    end
  end

  // new settings reach the PLL only when a calibration begins
  always_ff @(posedge clk) begin
    if (rst_all) begin
      bandwidth_active_r <= `ALFC_BW_RESET;
      rate_active_r <= `ALFC_RATE_RESET;
    end else if (cal_wr) begin
      bandwidth_active_r <= loop_bandwidth_select;
      rate_active_r <= input_rate_select;
    end
  end

endmodule

`default_nettype wire

/* File: src/alfc_defines.svh */
`ifndef ALFC_DEFINES_SVH
`define ALFC_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ALFC_OFF_ABSENT 8'h83
`define ALFC_OFF_OFFSET 8'h84
`define ALFC_OFF_ID_HI 8'h86
`define ALFC_OFF_ID_LO 8'h87
`define ALFC_OFF_CTRL 8'h88

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ALFC_BIT_IN2_ABSENT 2
`define ALFC_BIT_IN1_ABSENT 1
`define ALFC_BIT_REF_ABSENT 0
`define ALFC_BIT_IN2_OFFSET 3
`define ALFC_BIT_IN1_OFFSET 2
`define ALFC_BIT_UNLOCK 1
`define ALFC_BIT_SOFT_RESET 7
`define ALFC_BIT_CALIBRATE 6
`define ALFC_ID_HI_MSB 11
`define ALFC_ID_HI_LSB 4
`define ALFC_ID_LO_MSB 3
`define ALFC_ID_LO_LSB 0

// ----------------------------------------------------------------
// implemented bits and reset values
// ----------------------------------------------------------------
`define ALFC_ABSENT_BITS 8'h07
`define ALFC_OFFSET_BITS 8'h0e
`define ALFC_BYTE_ZERO 8'h00
`define ALFC_BW_RESET 4'h0
`define ALFC_RATE_RESET 3'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ALFC_SOFT_RESET_WAIT_MS 10
`define ALFC_CLK_KHZ 125000
`define ALFC_HOLD_W 21

`endif

/* File: src/alfc_pkg.sv */
package alfc_pkg;

  typedef logic [7:0] alfc_byte_t;

  // host sequencer states
  typedef enum logic [1:0] {
    ALFC_H_IDLE = 2'b00,
    ALFC_H_BUSY = 2'b01,
    ALFC_H_HOLD = 2'b10
  } alfc_hstate_t;

endpackage

/* File: src/alfc_if.sv */
`timescale 1ns/1ps
`default_nettype none

// register port between host and device, plus the interrupt pin
interface alfc_if;
  import alfc_pkg::*;

  logic req;
  logic we;
  alfc_byte_t addr;
  alfc_byte_t wdata;
  logic ack;
  alfc_byte_t rdata;
  logic irq;

  modport dev (
    input req,
    input we,
    input addr,
    input wdata,
    output ack,
    output rdata,
    output irq
  );

  modport host (
    output req,
    output we,
    output addr,
    output wdata,
    input ack,
    input rdata,
    input irq
  );

endinterface

`default_nettype wire

/* File: src/alfc_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "alfc_defines.svh"

module alfc_host #(
  parameter int unsigned HOLDOFF_CYCLES =
    `ALFC_SOFT_RESET_WAIT_MS * `ALFC_CLK_KHZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port and interrupt pin
  alfc_if.host port,
  // user command
  input wire logic cmd_valid,
  input wire logic cmd_we,
  input wire alfc_pkg::alfc_byte_t cmd_addr,
  input wire alfc_pkg::alfc_byte_t cmd_wdata,
  output logic cmd_ready_r,
  // user response
  output logic rsp_valid_r,
  output alfc_pkg::alfc_byte_t rsp_rdata_r,
  // status
  input wire logic clock_stable,
  output logic irq_seen_r,
  output logic cal_needed_r
);
  import alfc_pkg::*;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  alfc_hstate_t state_r;
  logic req_r;
  logic we_r;
  alfc_byte_t addr_r;
  alfc_byte_t wdata_r;
  logic rst_cmd_r;
  logic [`ALFC_HOLD_W-1:0] hold_r;
  logic ctrl_wr;
  logic cal_cmd;
  logic rst_cmd;
  logic cfg_cmd;
  logic take;

  assign ctrl_wr = cmd_we & (cmd_addr == `ALFC_OFF_CTRL);
  assign rst_cmd = ctrl_wr & cmd_wdata[`ALFC_BIT_SOFT_RESET];
  assign cal_cmd = ctrl_wr & cmd_wdata[`ALFC_BIT_CALIBRATE];
  // writes to any offset but the two flag registers and control are taken as device configuration
  assign cfg_cmd = cmd_we & (cmd_addr != `ALFC_OFF_ABSENT) &
                   (cmd_addr != `ALFC_OFF_OFFSET) & ~ctrl_wr;
  // a calibrate waits for a stable clock; ready stays high meanwhile
  assign take = cmd_valid & cmd_ready_r &
                (~cal_cmd | clock_stable);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ALFC_H_IDLE;
      req_r <= 1'b0;
      we_r <= 1'b0;
      addr_r <= `ALFC_BYTE_ZERO;
      wdata_r <= `ALFC_BYTE_ZERO;
      rst_cmd_r <= 1'b0;
      hold_r <= '0;
      cmd_ready_r <= 1'b1;
    end else begin
      unique case (state_r)
        ALFC_H_IDLE: begin
          if (take) begin
            state_r <= ALFC_H_BUSY;
            req_r <= 1'b1;
            we_r <= cmd_we;
            addr_r <= cmd_addr;
            wdata_r <= cmd_wdata;
            rst_cmd_r <= rst_cmd;
            cmd_ready_r <= 1'b0;
          end
        end
        ALFC_H_BUSY: begin
          if (port.ack) begin
            req_r <= 1'b0;
            if (rst_cmd_r) begin
              state_r <= ALFC_H_HOLD;
              hold_r <= `ALFC_HOLD_W'(HOLDOFF_CYCLES - 1);
            end else begin
              state_r <= ALFC_H_IDLE;
              cmd_ready_r <= 1'b1;
            end
          end
        end
        ALFC_H_HOLD: begin
          // port stays silent while the device comes out of reset
          if (hold_r == '0) begin
            state_r <= ALFC_H_IDLE;
            cmd_ready_r <= 1'b1;
          end else begin
            hold_r <= hold_r - 1'b1;
          end
        end
        default: begin
          state_r <= ALFC_H_IDLE;
          req_r <= 1'b0;
          cmd_ready_r <= 1'b1;
        end
      endcase
    end
  end

  assign port.req = req_r;
  assign port.we = we_r;
  assign port.addr = addr_r;
  assign port.wdata = wdata_r;

  // ----------------------------------------------------------------
  // response and status
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rsp_valid_r <= 1'b0;
      rsp_rdata_r <= `ALFC_BYTE_ZERO;
    end else begin
      rsp_valid_r <= (state_r == ALFC_H_BUSY) & port.ack;
      if ((state_r == ALFC_H_BUSY) & port.ack) begin
        rsp_rdata_r <= port.rdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_seen_r <= 1'b0;
    end else begin
      irq_seen_r <= port.irq;
    end
  end

  // flags that a calibration is owed before the device is usable
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cal_needed_r <= 1'b1;
    end else if (take & rst_cmd) begin
      cal_needed_r <= 1'b1;
    end else if (take & cal_cmd) begin
      cal_needed_r <= 1'b0;
    end else if (take & cfg_cmd) begin
      cal_needed_r <= 1'b1;
    end
  end

endmodule

`default_nettype wire

/* File: verification/alfc_chk.sv */
`timescale 1ns/1ps
`default_nettype none

module alfc_chk #(
  parameter logic [11:0] PART_ID = 12'h5a3, // arbitrary value
  parameter logic [3:0] REV_ID = 4'hb // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic req,
  input wire logic we,
  input wire alfc_pkg::alfc_byte_t addr,
  input wire alfc_pkg::alfc_byte_t wdata,
  input wire logic ack,
  input wire alfc_pkg::alfc_byte_t rdata,
  input wire logic irq
);
  import alfc_pkg::*;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // a request is taken at any edge where it is up and not yet answered
  logic take;
  assign take = req && !ack;

  // ----------------------------------------------------------------
  // handshake
  // ----------------------------------------------------------------
  a_ack_after_take: assert property (take |=> ack)
    else $error("no answer one cycle after a taken request");
  a_ack_one_cycle: assert property (ack |=> !ack)
    else $error("answer longer than one cycle");
  a_ack_has_cause: assert property (ack |-> $past(take))
    else $error("answer without a taken request");
  a_req_held: assert property (take |=> req && $stable({we, addr, wdata}))
    else $error("request changed before its answer");
  a_req_release: assert property (ack |=> !req)
    else $error("request not released after answer");

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  a_id_high: assert property (take && !we && addr == 8'h86 |=>
    rdata == PART_ID[11:4])
    else $error("wrong upper identifier byte");
  a_id_low: assert property (take && !we && addr == 8'h87 |=>
    rdata == {PART_ID[3:0], REV_ID})
    else $error("wrong lower identifier and revision byte");
  a_ctrl_reads_zero: assert property (take && !we && addr == 8'h88 |=>
    rdata == 8'h00)
    else $error("control bits did not read back zero");
  a_absent_reserved: assert property (take && !we && addr == 8'h83 |=>
    rdata[7:3] == 5'h00)
    else $error("reserved absence bits not zero");
  a_offset_reserved: assert property (take && !we && addr == 8'h84 |=>
    rdata[7:4] == 4'h0 && !rdata[0])
    else $error("reserved offset bits not zero");
  a_reset_quiet: assert property (disable iff (1'b0)
    sys_rst |=> !ack && !irq)
    else $error("outputs active after reset");

  c_write: cover property (take && we);
  c_read: cover property (take && !we);
  c_irq: cover property ($rose(irq));

endmodule

`default_nettype wire

/* File: verification/alarm_flag_and_control_regs_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module alarm_flag_and_control_regs_bench;
  import alfc_pkg::*;

  localparam logic [11:0] PART_ID = 12'h3c9; // arbitrary value
  localparam logic [3:0] REV_ID = 4'h6; // arbitrary value
  // short holdoff keeps the soft reset wait inside a small run
  localparam int HOLD = 20;

  logic clk;
  logic sys_rst = 1'b1;
  logic [5:0] live_v = 6'h00;
  logic [5:0] mask_v = 6'h00;
  logic int_en = 1'b0;
  logic [3:0] bw_sel = 4'h0;
  logic [2:0] rate_sel = 3'h0;
  logic cmd_valid = 1'b0;
  logic cmd_we = 1'b0;
  alfc_byte_t cmd_addr = 8'h00;
  alfc_byte_t cmd_wdata = 8'h00;
  logic clock_stable = 1'b1;
  logic cal_start, calibrating, logic_reset, cmd_ready, rsp_valid;
  logic irq_seen, cal_needed;
  logic [3:0] bw_act;
  logic [2:0] rate_act;
  alfc_byte_t rsp_rdata;
  int n_errors = 0;
  int checked = 0;
  int n_cal = 0;
  int n_rst = 0;

  alfc_if alfc_if_inst ();

  alfc_device #(.PART_ID(PART_ID), .REV_ID(REV_ID)) alfc_device_inst (
    .clk(clk), .sys_rst(sys_rst), .port(alfc_if_inst.dev),
    .ref_absent_live(live_v[0]), .in1_absent_live(live_v[1]),
    .in2_absent_live(live_v[2]), .unlock_live(live_v[3]),
    .in1_offset_live(live_v[4]), .in2_offset_live(live_v[5]),
    .ref_absent_mask(mask_v[0]), .in1_absent_mask(mask_v[1]),
    .in2_absent_mask(mask_v[2]), .unlock_mask(mask_v[3]),
    .in1_offset_mask(mask_v[4]), .in2_offset_mask(mask_v[5]),
    .int_pin_enable(int_en), .loop_bandwidth_select(bw_sel),
    .input_rate_select(rate_sel), .cal_start_r(cal_start),
    .calibrating_r(calibrating), .bandwidth_active_r(bw_act),
    .rate_active_r(rate_act), .logic_reset_r(logic_reset));

  alfc_host #(.HOLDOFF_CYCLES(HOLD)) alfc_host_inst (
    .clk(clk), .sys_rst(sys_rst), .port(alfc_if_inst.host),
    .cmd_valid(cmd_valid), .cmd_we(cmd_we), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ready_r(cmd_ready),
    .rsp_valid_r(rsp_valid), .rsp_rdata_r(rsp_rdata),
    .clock_stable(clock_stable), .irq_seen_r(irq_seen),
    .cal_needed_r(cal_needed));

  alfc_chk #(.PART_ID(PART_ID), .REV_ID(REV_ID)) alfc_chk_inst (
    .clk(clk), .sys_rst(sys_rst), .req(alfc_if_inst.req),
    .we(alfc_if_inst.we), .addr(alfc_if_inst.addr),
    .wdata(alfc_if_inst.wdata), .ack(alfc_if_inst.ack),
    .rdata(alfc_if_inst.rdata), .irq(alfc_if_inst.irq));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // pulses are one cycle long, so they are counted where they happen
  always @(posedge clk) begin
    if (cal_start === 1'b1) n_cal <= n_cal + 1;
    if (logic_reset === 1'b1) n_rst <= n_rst + 1;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic wrap_up();
    if (n_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk_byte(input alfc_byte_t got, input alfc_byte_t exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t byte got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t bit got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic xfer(input logic w, input alfc_byte_t a,
                      input alfc_byte_t d, output alfc_byte_t q,
                      output logic got);
    int i;
    got = 1'b0;
    q = 8'h00;
    i = 0;
    while (cmd_ready !== 1'b1 && i < 100) begin
      tick(1);
      i++;
    end
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_we <= w;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    for (i = 0; i < 8 && !got; i++) begin
      tick(1);
      if (rsp_valid === 1'b1) begin
        got = 1'b1;
        q = rsp_rdata;
      end
    end
  endtask

  task automatic rd_chk(input alfc_byte_t a, input alfc_byte_t exp);
    alfc_byte_t q;
    logic g;
    xfer(1'b0, a, 8'h00, q, g);
    chk_bit(g, 1'b1);
    chk_byte(q, exp);
  endtask

  task automatic wr(input alfc_byte_t a, input alfc_byte_t d);
    alfc_byte_t q;
    logic g;
    xfer(1'b1, a, d, q, g);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_ids();
    rd_chk(8'h86, PART_ID[11:4]);
    rd_chk(8'h87, {PART_ID[3:0], REV_ID});
    wr(8'h86, 8'hff);
    rd_chk(8'h86, PART_ID[11:4]);
    rd_chk(8'h85, 8'h00);
    wr(8'h83, 8'hff);
    rd_chk(8'h83, 8'h00);
    rd_chk(8'h88, 8'h00);
  endtask

  task automatic t_flags();
    int i;
    alfc_byte_t a;
    alfc_byte_t m;
    for (i = 0; i < 6; i++) begin
      a = (i < 3) ? 8'h83 : 8'h84;
      m = 8'h01 << ((i < 3) ? i : i - 2);
      live_v[i] <= 1'b1;
      tick(1);
      live_v[i] <= 1'b0;
      tick(3);
      rd_chk(a, m);
      wr(a, ~m);
      rd_chk(a, 8'h00);
    end
    live_v[2] <= 1'b1;
    tick(1);
    wr(8'h83, 8'h00);
    rd_chk(8'h83, 8'h04);
    live_v[2] <= 1'b0;
    wr(8'h83, 8'h00);
    rd_chk(8'h83, 8'h00);
  endtask

  task automatic t_irq();
    int_en <= 1'b1;
    live_v[5] <= 1'b1;
    tick(1);
    live_v[5] <= 1'b0;
    tick(2);
    chk_bit(alfc_if_inst.irq, 1'b1);
    mask_v[5] <= 1'b1;
    tick(2);
    chk_bit(alfc_if_inst.irq, 1'b0);
    rd_chk(8'h84, 8'h08);
    mask_v[5] <= 1'b0;
    int_en <= 1'b0;
    tick(2);
    chk_bit(alfc_if_inst.irq, 1'b0);
    int_en <= 1'b1;
    tick(3);
    chk_bit(irq_seen, 1'b1);
    wr(8'h84, 8'h00);
    tick(2);
    chk_bit(alfc_if_inst.irq, 1'b0);
  endtask

  task automatic t_cal();
    alfc_byte_t q;
    logic g;
    chk_bit(cal_needed, 1'b1);
    bw_sel <= 4'h9;
    rate_sel <= 3'h5;
    clock_stable <= 1'b0;
    xfer(1'b1, 8'h88, 8'h40, q, g);
    chk_bit(g, 1'b0);
    chk_byte({1'b0, rate_act, bw_act}, 8'h00);
    clock_stable <= 1'b1;
    live_v[3] <= 1'b1;
    wr(8'h88, 8'h40);
    chk_bit(n_cal == 1, 1'b1);
    chk_bit(calibrating, 1'b1);
    chk_bit(cal_needed, 1'b0);
    chk_byte({1'b0, rate_act, bw_act}, 8'h59);
    rd_chk(8'h88, 8'h00);
    live_v[3] <= 1'b0;
    tick(2);
    chk_bit(calibrating, 1'b0);
  endtask

  task automatic t_soft();
    live_v[0] <= 1'b1;
    tick(1);
    live_v[0] <= 1'b0;
    wr(8'h88, 8'h80);
    chk_bit(n_rst == 1, 1'b1);
    tick(10);
    chk_bit(cmd_ready, 1'b0);
    rd_chk(8'h83, 8'h00);
    rd_chk(8'h84, 8'h00);
    chk_byte({1'b0, rate_act, bw_act}, 8'h00);
    chk_bit(cal_needed, 1'b1);
    wr(8'h88, 8'h40);
    chk_bit(cal_needed, 1'b0);
    wr(8'h90, 8'h01);
    chk_bit(cal_needed, 1'b1);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    tick(1);
    t_ids();
    t_flags();
    t_irq();
    t_cal();
    t_soft();
    wrap_up();
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    #40000;
    n_errors++;
    wrap_up();
  end

endmodule

`default_nettype wire
